// [inc/acs_regs.vh]
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// Calibration sequence length in convert clock cycles.
`define ACS_CAL_CYCLES 32'd32775
// Clocks spent flushing after busy drops, before converter words are accepted again.
`define ACS_FLUSH_CYCLES 4'd7
// Power-on delay before the automatic calibration, 2 to the 21st clocks.
`define ACS_POWERON_CYCLES 32'd2097152
// Strap codes for the range select input.
`define ACS_SEL_TIED_VREF 2'h0
`define ACS_SEL_GROUND 2'h1
`define ACS_SEL_SUPPLY 2'h2
// Sequencer state codes.
`define ACS_ST_WAIT 3'h0
`define ACS_ST_IDLE 3'h1
`define ACS_ST_HELD 3'h2
`define ACS_ST_CAL 3'h3
`define ACS_ST_FLUSH 3'h4
// Width of the sample word.
`define ACS_WORD_W 14

`endif

// [src/acs_fifo.v]
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk,
    input wire reset,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (reset || flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// [src/acs_sequencer.v]
// How it works
// - Correction registers clear on the rising edge of the request.
// - A requested calibration sequence starts only when the request falls.
// - Calibration lasts a fixed 32,775 convert clock cycles.
// - While calibrating, busy is high and sample outputs are zero.
// - Analog input samples are ignored for the whole calibration.
// - Busy drops at the end; first valid word nine clocks later.
// - After power-up wait 2^21 clocks, then calibrate automatically.
// - Range strap picks a 1 V or 2 V internal reference.
// - Range strap at supply shuts the reference and its buffer off.
// - Format select high gives two's complement, low offset binary.
// - Out-of-range flag travels with its sample word, same latency.
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_sequencer #(
    parameter WORD_W = `ACS_WORD_W,
    parameter CAL_CYCLES = `ACS_CAL_CYCLES,
    parameter POWERON_CYCLES = `ACS_POWERON_CYCLES,
    parameter FIFO_DEPTH = 8
) (
    input wire ref_clk,
    input wire reset,
    input wire cal_request,
    input wire twos_complement_select,
    input wire [1:0] range_select,
    input wire [WORD_W-1:0] conv_word,
    input wire conv_over,
    input wire conv_valid,
    output wire conv_ready,
    output reg [WORD_W-1:0] sample_word,
    output reg out_of_range_flag,
    output reg sample_valid,
    input wire sample_ready,
    output reg cal_busy,
    output reg corr_clear,
    output reg cal_run,
    output reg ref_2v_select,
    output reg ref_enable,
    output reg ref_buffer_connect
);
    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    reg req_meta;
    reg req_sync;
    reg req_prev;
    reg fmt_meta;
    reg fmt_sync;
    reg [1:0] sel_meta;
    reg [1:0] sel_sync;

    always @(posedge ref_clk) begin
        if (reset) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
            fmt_meta <= 1'b0;
            fmt_sync <= 1'b0;
            sel_meta <= `ACS_SEL_TIED_VREF;
            sel_sync <= `ACS_SEL_TIED_VREF;
        end else begin
            req_meta <= cal_request;
            req_sync <= req_meta;
            req_prev <= req_sync;
            fmt_meta <= twos_complement_select;
            fmt_sync <= fmt_meta;
            sel_meta <= range_select;
            sel_sync <= sel_meta;
        end
    end

    wire req_rise;
    wire req_fall;
    assign req_rise = req_sync && !req_prev;
    assign req_fall = !req_sync && req_prev;

    // ------------------------------------------------------------------
    // Calibration sequencer.
    // ------------------------------------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] count;
    reg [31:0] next_count;
    wire calibrating;

    // Busy covers the held request too, so no sample leaks out meanwhile.
    assign calibrating = (state == `ACS_ST_CAL) || (state == `ACS_ST_HELD) ||
                         (state == `ACS_ST_WAIT);

    always @* begin
        next_state = state;
        next_count = count + 32'd1;
        case (state)
            `ACS_ST_WAIT: begin
                if (count == POWERON_CYCLES - 1) begin
                    next_state = `ACS_ST_CAL;
                    next_count = 32'd0;
                end
                if (req_rise) begin
                    next_state = `ACS_ST_HELD;
                end
            end
            `ACS_ST_IDLE: begin
                next_count = 32'd0;
                if (req_rise) begin
                    next_state = `ACS_ST_HELD;
                end
            end
            `ACS_ST_HELD: begin
                next_count = 32'd0;
                if (req_fall) begin
                    next_state = `ACS_ST_CAL;
                end
            end
            `ACS_ST_CAL: begin
                if (req_rise) begin
                    next_state = `ACS_ST_HELD;
                    next_count = 32'd0;
                end else if (count == CAL_CYCLES - 1) begin
                    next_state = `ACS_ST_FLUSH;
                    next_count = 32'd0;
                end
            end
            `ACS_ST_FLUSH: begin
                if (req_rise) begin
                    next_state = `ACS_ST_HELD;
                end else if (count == {28'd0, `ACS_FLUSH_CYCLES} - 32'd1) begin
                    next_state = `ACS_ST_IDLE;
                    next_count = 32'd0;
                end
            end
            default: begin
                next_state = `ACS_ST_IDLE;
                next_count = 32'd0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            state <= `ACS_ST_WAIT;
            count <= 32'd0;
            cal_busy <= 1'b1;
            corr_clear <= 1'b0;
            cal_run <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            cal_busy <= (next_state == `ACS_ST_CAL) || (next_state == `ACS_ST_HELD) ||
                        (next_state == `ACS_ST_WAIT);
            corr_clear <= req_rise;
            cal_run <= (next_state == `ACS_ST_CAL);
        end
    end

    // ------------------------------------------------------------------
    // Reference strap decode.
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            ref_2v_select <= 1'b0;
            ref_enable <= 1'b0;
            ref_buffer_connect <= 1'b0;
        end else begin
            ref_2v_select <= (sel_sync == `ACS_SEL_GROUND);
            ref_enable <= (sel_sync != `ACS_SEL_SUPPLY);
            ref_buffer_connect <= (sel_sync != `ACS_SEL_SUPPLY);
        end
    end

    // ------------------------------------------------------------------
    // Sample path through the FIFO.
    // ------------------------------------------------------------------
    wire quiet;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire fifo_in_ready;
    wire [WORD_W:0] fifo_out_data;
    wire [WORD_W-1:0] fmt_word;

    // Converter words are dropped while calibrating or flushing.
    assign quiet = calibrating || (state == `ACS_ST_FLUSH);
    assign conv_ready = fifo_in_ready || quiet;
    assign fmt_word = fmt_sync ? {~conv_word[WORD_W-1], conv_word[WORD_W-2:0]} :
                      conv_word;
    assign fifo_out_ready = !sample_valid || sample_ready;

    acs_fifo #(
        .WIDTH(WORD_W + 1),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .flush(quiet),
        .in_valid(conv_valid && !quiet),
        .in_ready(fifo_in_ready),
        .in_data({conv_over, fmt_word}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    always @(posedge ref_clk) begin
        if (reset) begin
            sample_word <= {WORD_W{1'b0}};
            out_of_range_flag <= 1'b0;
            sample_valid <= 1'b0;
        end else if (quiet) begin
            sample_word <= {WORD_W{1'b0}};
            out_of_range_flag <= 1'b0;
            sample_valid <= 1'b0;
        end else if (fifo_out_ready) begin
            sample_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                sample_word <= fifo_out_data[WORD_W-1:0];
                out_of_range_flag <= fifo_out_data[WORD_W];
            end
        end
    end
endmodule

// [tb/acs_host_model.sv]
`timescale 1ns/10ps
module acs_host_model (
    input wire ref_clk,
    input wire stall,
    output reg sample_ready = 1'b0
);
    // Ready drops while stalled, so the sample buffer backs up.
    always @(negedge ref_clk) begin
        sample_ready <= !stall;
    end
endmodule

// [tb/acs_seq_asserts.sv]
`timescale 1ns/10ps
module acs_seq_asserts #(
    parameter WORD_W = 14,
    parameter CAL_CYCLES = 40
) (
    input wire ref_clk,
    input wire reset,
    input wire cal_request,
    input wire [1:0] range_select,
    input wire [WORD_W-1:0] sample_word,
    input wire sample_valid,
    input wire cal_busy,
    input wire corr_clear,
    input wire cal_run,
    input wire ref_enable,
    input wire ref_buffer_connect
);
    reg [31:0] run_len = 32'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence quiet_s; !sample_valid [*7]; endsequence
    sequence ext_s; (range_select == 2'h2) [*3]; endsequence
    always @(posedge ref_clk) begin
        run_len <= (reset || !cal_run) ? 32'h0 : run_len + 32'h1;
    end
    chk_run_quiet: assert property (
        cal_run |-> cal_busy && sample_word == 0 && !sample_valid) else $error("not quiet");
    chk_run_length: assert property ($fell(cal_run) |-> run_len == CAL_CYCLES)
        else $error("run length");
    chk_clear_rise: assert property ($rose(cal_request) |-> ##[1:5] corr_clear)
        else $error("no clear");
    chk_no_early: assert property (cal_request |-> !$rose(cal_run))
        else $error("early run");
    chk_fall_start: assert property ($fell(cal_request) |-> ##[1:6] cal_run)
        else $error("no start");
    chk_flush_gap: assert property ($fell(cal_busy) |-> quiet_s)
        else $error("early word");
    chk_busy_end: assert property ($fell(cal_run) |-> ##[0:1] !cal_busy)
        else $error("busy stuck");
    chk_strap_ext: assert property (ext_s |=> !ref_enable && !ref_buffer_connect)
        else $error("ref on");
endmodule
bind acs_sequencer acs_seq_asserts #(
    .WORD_W(WORD_W), .CAL_CYCLES(CAL_CYCLES)) acs_seq_asserts_i (
    .ref_clk, .reset, .cal_request, .range_select, .sample_word, .sample_valid,
    .cal_busy, .corr_clear, .cal_run, .ref_enable, .ref_buffer_connect);

// [tb/acs_sequencer_bench.sv]
`timescale 1ns/10ps
module acs_sequencer_bench;
    localparam CAL = 40;
    reg ref_clk = 1'b0;
    reg reset = 1'b1;
    reg cal_request = 1'b0;
    reg twos_complement_select = 1'b0;
    reg [1:0] range_select = 2'h0;
    reg conv_over = 1'b0;
    reg stall = 1'b0;
    wire [13:0] sample_word;
    wire conv_ready, out_of_range_flag, sample_valid, sample_ready, cal_busy;
    wire corr_clear, cal_run, ref_2v_select, ref_enable, ref_buffer_connect;
    integer err_count = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer n, f;
    always #20 ref_clk = ~ref_clk;
    acs_host_model acs_host_model_i (.ref_clk, .stall, .sample_ready);
    acs_sequencer #(.CAL_CYCLES(CAL), .POWERON_CYCLES(64)) acs_sequencer_i (
        .ref_clk, .reset, .cal_request, .twos_complement_select, .range_select,
        .conv_word(14'h0123), .conv_over, .conv_valid(1'b1), .conv_ready, .sample_word,
        .out_of_range_flag, .sample_valid, .sample_ready, .cal_busy, .corr_clear,
        .cal_run, .ref_2v_select, .ref_enable, .ref_buffer_connect);
    task check(input [63:0] what, input [31:0] seen, exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("BAD %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task run_cal;
        begin
            n = 0;
            while (cal_run !== 1'b1 && n < 99) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            n = 0;
            while (cal_run === 1'b1 && n < 99) begin
                check("quiet", {cal_busy, sample_word, sample_valid}, 16'h8000);
                @(negedge ref_clk);
                n = n + 1;
            end
            check("length", n, CAL);
            while (sample_valid !== 1'b1 && n < 150) begin
                @(negedge ref_clk);
                n = n + 1;
            end
        end
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (60) begin
            check("wait", {cal_run, cal_busy, sample_word, sample_valid}, 17'h8000);
            @(negedge ref_clk);
        end
        run_cal;
        $display("test power_on done");
        for (f = 0; f < 2; f = f + 1) begin
            twos_complement_select = f[0];
            conv_over = f[0];
            cal_request = 1'b1;
            repeat (2) @(negedge ref_clk);
            cal_request = 1'b0;
            run_cal;
            check("word", {out_of_range_flag, sample_word}, {f[0], f[0], 13'h0123});
            $display("test request %0d done", f);
        end
        stall = 1'b1;
        repeat (20) @(negedge ref_clk);
        check("full", {conv_ready, sample_valid}, 2'h1);
        stall = 1'b0;
        repeat (20) @(negedge ref_clk);
        check("drain", conv_ready, 1);
        $display("test buffer done");
        for (f = 0; f < 3; f = f + 1) begin
            range_select = f[1:0];
            repeat (4) @(negedge ref_clk);
            check("ref", {ref_2v_select, ref_enable, ref_buffer_connect},
                f == 2 ? 3'h0 : {f[0], 2'h3});
        end
        $display("test strap done");
        print_verdict;
    end
endmodule
